// ==== pkg/analog_cfg_pkg.sv ====
package analog_cfg_pkg;

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	// printed offsets 0x32 and 0x3B are not multiples of four, so every printed
	// offset is kept as a register index; the byte address is four times it
	localparam logic [7:0]  IDX_RANGE_A   = 8'h30; // full-scale code, input a
	localparam logic [7:0]  IDX_RANGE_B   = 8'h32; // full-scale code, input b
	localparam logic [7:0]  IDX_REF_SEL   = 8'h38; // reference source select
	localparam logic [7:0]  IDX_STAMP     = 8'h3B; // timestamp receiver control
	localparam logic [7:0]  IDX_EMPHASIS  = 8'h48; // serializer pre-emphasis
	localparam logic [7:0]  IDX_INPUT_SEL = 8'h60; // input mux select
	localparam logic [7:0]  IDX_CAL_CTRL  = 8'h61; // calibration enable
	localparam logic [7:0]  IDX_STATUS    = 8'h70; // applied mux state, read only

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          BIT_USE_SUPPLY   = 0;  // reference select
	localparam int          BIT_STAMP_ON     = 0;  // receiver enable
	localparam int          BIT_STAMP_PECL   = 1;  // pecl signalling
	localparam int          BIT_EMPH_EXTRA   = 3;  // boost bit
	localparam int          BIT_DUAL_SWAP    = 4;  // dual-channel swap
	localparam int          BIT_CAL_ENABLE   = 0;  // calibration enable

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_RANGE        = 16'hA000;
	localparam logic [7:0]  RST_REF_SEL      = 8'h00;
	localparam logic [7:0]  RST_STAMP        = 8'h00;
	localparam logic [7:0]  RST_EMPHASIS     = 8'h00;
	localparam logic [7:0]  RST_INPUT_SEL    = 8'h01;
	localparam logic [7:0]  RST_CAL_CTRL     = 8'h01;

	// ------------------------------------------------------------
	// single-channel input codes
	// ------------------------------------------------------------
	localparam logic [1:0]  SEL_RESERVED     = 2'h0;
	localparam logic [1:0]  SEL_INPUT_A      = 2'h1;
	localparam logic [1:0]  SEL_INPUT_B      = 2'h2;
	localparam logic [1:0]  SEL_BOTH         = 2'h3;

	// axi responses
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage : analog_cfg_pkg

// ==== rtl/input_route.sv ====
// decodes the applied mux setting into per-channel input selects
module input_route (
	input  wire logic [7:0] applied_sel,   // mux byte latched at calibration
	input  wire logic       single_mode,   // operating mode is single-channel
	output logic            chan_a_from_b, // channel a samples input b
	output logic            chan_b_from_a, // channel b samples input a
	output logic            sel_reserved   // reserved single-channel code
);
	logic [1:0] single_code; // single-channel field
	logic       swap;        // dual-channel swap bit

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// each field is masked by the mode, so the other field has no effect
	always_comb
	begin
		single_code   = applied_sel[1:0];
		swap          = applied_sel[analog_cfg_pkg::BIT_DUAL_SWAP];
		chan_a_from_b = 1'b0;
		chan_b_from_a = 1'b0;
		sel_reserved  = 1'b0;
		if (single_mode)
		begin
			// swap bit ignored here [R10]
			case (single_code) // [R11] [R12]
				analog_cfg_pkg::SEL_INPUT_A:
				begin
					chan_a_from_b = 1'b0; // both sample input a
					chan_b_from_a = 1'b1;
				end
				analog_cfg_pkg::SEL_INPUT_B:
				begin
					chan_a_from_b = 1'b1; // both sample input b
					chan_b_from_a = 1'b0;
				end
				analog_cfg_pkg::SEL_BOTH:
				begin
					chan_a_from_b = 1'b0; // a from a, b from b
					chan_b_from_a = 1'b0;
				end
				default:
					sel_reserved = 1'b1; // code 0, keep straight routing
			endcase
		end
		else
		begin
			// single field ignored here [R12]
			chan_a_from_b = swap; // [R9]
			chan_b_from_a = swap; // [R9]
		end
	end

endmodule : input_route

// ==== rtl/analog_cfg_regs.sv ====
// Behaviour
// R1 - input a full-scale code, reset 0xA000
// R2 - input b full-scale code, reset 0xA000
// R3 - software keeps codes 0x2000 to 0xFFFF
// R4 - bit 0 selects supply as reference
// R5 - bit 0 enables timestamp receiver
// R6 - bit 1 selects pecl receiver signalling
// R7 - three-bit emphasis level for all lanes
// R8 - bit 3 adds extra emphasis boost
// R9 - dual mode: bit 4 swaps inputs
// R10 - swap bit ignored in single mode
// R11 - single field: 1 a, 2 b, 3 both
// R12 - single field ignored in dual mode
// R13 - mux change applies only after calibration
// R14 - input mux resets to 0x01
// R15 - calibration runs on enable rising again
// R16 - reserved bits read back, reset zero
// R17 - fields read back, reset to defaults
module analog_cfg_regs (
	input  wire logic        aclk,                     // 20 MHz bus clock
	input  wire logic        aresetn,                  // synchronous reset, active low
	input  wire logic [9:0]  s_axi_awaddr,             // write address
	input  wire logic        s_axi_awvalid,            // write address valid
	output logic             s_axi_awready,            // write address ready
	input  wire logic [31:0] s_axi_wdata,              // write data
	input  wire logic [3:0]  s_axi_wstrb,              // write byte strobes
	input  wire logic        s_axi_wvalid,             // write data valid
	output logic             s_axi_wready,             // write data ready
	output logic [1:0]       s_axi_bresp,              // write response
	output logic             s_axi_bvalid,             // write response valid
	input  wire logic        s_axi_bready,             // write response ready
	input  wire logic [9:0]  s_axi_araddr,             // read address
	input  wire logic        s_axi_arvalid,            // read address valid
	output logic             s_axi_arready,            // read address ready
	output logic [31:0]      s_axi_rdata,              // read data
	output logic [1:0]       s_axi_rresp,              // read response
	output logic             s_axi_rvalid,             // read data valid
	input  wire logic        s_axi_rready,             // read data ready
	input  wire logic        operating_mode_single,    // mode selector picks a single-channel mode
	output logic [15:0]      range_code_a,             // full-scale trim, input a
	output logic [15:0]      range_code_b,             // full-scale trim, input b
	output logic             use_supply_reference,     // supply instead of band-gap
	output logic             stamp_receiver_on,        // timestamp receiver enable
	output logic             stamp_receiver_pecl_mode, // receiver pecl signalling
	output logic [2:0]       lane_emphasis_level,      // pre-emphasis, all 16 lanes
	output logic             lane_emphasis_extra,      // extra boost
	output logic             calibration_run,          // calibration enable level
	output logic             chan_a_from_b,            // channel a samples input b
	output logic             chan_b_from_a             // channel b samples input a
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		W_IDLE = 2'b00, // gathering address and data
		W_RESP = 2'b01  // response offered
	} wr_state_e;

	typedef struct packed {
		logic [15:0] range_a;     // full-scale code a
		logic [15:0] range_b;     // full-scale code b
		logic [7:0]  ref_sel;     // reference select byte
		logic [7:0]  stamp;       // timestamp control byte
		logic [7:0]  emphasis;    // serializer emphasis byte
		logic [7:0]  input_sel;   // mux byte as written
		logic [7:0]  cal_ctrl;    // calibration control byte
		logic [7:0]  applied_sel; // mux byte in force
		wr_state_e   wst;         // write channel state
		logic        aw_held;     // write address captured
		logic        w_held;      // write data captured
		logic [9:0]  awaddr;      // captured write address
		logic [31:0] wdata;       // captured write data
		logic [3:0]  wstrb;       // captured strobes
		logic [1:0]  bresp;       // pending write response
		logic        rvalid;      // read data offered
		logic [31:0] rdata;       // read data
		logic [1:0]  rresp;       // read response
	} regs_s;

	regs_s      st;           // registered state
	regs_s      next_st;      // next state
	logic       sel_reserved; // reserved single code in force
	logic [7:0] widx;         // write register index
	logic [7:0] ridx;         // read register index
	logic       cal_rise;     // calibration enable just set

	// ------------------------------------------------------------
	// index helpers
	// ------------------------------------------------------------
	// unaligned addresses are answered like their containing word
	assign widx     = st.awaddr[9:2];
	assign ridx     = s_axi_araddr[9:2];
	assign cal_rise = next_st.cal_ctrl[analog_cfg_pkg::BIT_CAL_ENABLE] &
		~st.cal_ctrl[analog_cfg_pkg::BIT_CAL_ENABLE];

	// merges strobed bytes into a register image
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// write address and data accepted independently, in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_held = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wstrb  = s_axi_wstrb;
		end
		case (st.wst)
			W_IDLE:
			begin
				if (st.aw_held && st.w_held)
				begin
					next_st.aw_held = 1'b0;
					next_st.w_held  = 1'b0;
					next_st.wst     = W_RESP;
					next_st.bresp   = analog_cfg_pkg::RESP_OKAY;
					// every bit, reserved ones too, stores and reads back [R16] [R17]
					case (widx)
						analog_cfg_pkg::IDX_RANGE_A:
							next_st.range_a = merge(st.range_a, st.wdata, st.wstrb); // [R1]
						analog_cfg_pkg::IDX_RANGE_B:
							next_st.range_b = merge(st.range_b, st.wdata, st.wstrb); // [R2]
						analog_cfg_pkg::IDX_REF_SEL:
							next_st.ref_sel = st.wstrb[0] ? st.wdata[7:0] : st.ref_sel; // [R4]
						analog_cfg_pkg::IDX_STAMP:
							next_st.stamp = st.wstrb[0] ? st.wdata[7:0] : st.stamp; // [R5] [R6]
						analog_cfg_pkg::IDX_EMPHASIS:
							next_st.emphasis = st.wstrb[0] ? st.wdata[7:0] : st.emphasis; // [R7] [R8]
						analog_cfg_pkg::IDX_INPUT_SEL:
							next_st.input_sel = st.wstrb[0] ? st.wdata[7:0] : st.input_sel;
						analog_cfg_pkg::IDX_CAL_CTRL:
							next_st.cal_ctrl = st.wstrb[0] ? st.wdata[7:0] : st.cal_ctrl; // [R15]
						analog_cfg_pkg::IDX_STATUS:
							next_st.bresp = analog_cfg_pkg::RESP_SLVERR; // read only
						default:
							next_st.bresp = analog_cfg_pkg::RESP_SLVERR; // unmapped
					endcase
				end
			end
			W_RESP:
			begin
				if (s_axi_bready)
					next_st.wst = W_IDLE;
			end
			default:
				next_st.wst = W_IDLE;
		endcase
		// mux setting reaches the sampler only when calibration starts [R13] [R15]
		// edge taken from next_st here, not from cal_rise, so this process feeds no loop back into itself
		if (next_st.cal_ctrl[analog_cfg_pkg::BIT_CAL_ENABLE] && !st.cal_ctrl[analog_cfg_pkg::BIT_CAL_ENABLE])
			next_st.applied_sel = next_st.input_sel;
		// read channel: one read at a time, data one cycle after address
		if (st.rvalid)
		begin
			if (s_axi_rready)
				next_st.rvalid = 1'b0;
		end
		else if (s_axi_arvalid)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = analog_cfg_pkg::RESP_OKAY;
			case (ridx)
				analog_cfg_pkg::IDX_RANGE_A:   next_st.rdata = {16'h0000, st.range_a};
				analog_cfg_pkg::IDX_RANGE_B:   next_st.rdata = {16'h0000, st.range_b};
				analog_cfg_pkg::IDX_REF_SEL:   next_st.rdata = {24'h000000, st.ref_sel};
				analog_cfg_pkg::IDX_STAMP:     next_st.rdata = {24'h000000, st.stamp};
				analog_cfg_pkg::IDX_EMPHASIS:  next_st.rdata = {24'h000000, st.emphasis};
				analog_cfg_pkg::IDX_INPUT_SEL: next_st.rdata = {24'h000000, st.input_sel};
				analog_cfg_pkg::IDX_CAL_CTRL:  next_st.rdata = {24'h000000, st.cal_ctrl};
				analog_cfg_pkg::IDX_STATUS:    next_st.rdata = {23'h000000, sel_reserved, st.applied_sel};
				default:
				begin
					next_st.rdata = 32'h00000000; // unmapped reads zero
					next_st.rresp = analog_cfg_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st             <= '0;
			st.range_a     <= analog_cfg_pkg::RST_RANGE;     // [R1] [R17]
			st.range_b     <= analog_cfg_pkg::RST_RANGE;     // [R2] [R17]
			st.ref_sel     <= analog_cfg_pkg::RST_REF_SEL;   // [R4] [R16]
			st.stamp       <= analog_cfg_pkg::RST_STAMP;     // [R5] [R6]
			st.emphasis    <= analog_cfg_pkg::RST_EMPHASIS;  // [R7]
			st.input_sel   <= analog_cfg_pkg::RST_INPUT_SEL; // [R14]
			st.applied_sel <= analog_cfg_pkg::RST_INPUT_SEL; // [R14]
			st.cal_ctrl    <= analog_cfg_pkg::RST_CAL_CTRL;  // [R15]
			st.wst         <= W_IDLE;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// holding address until data arrives keeps one write in flight
	assign s_axi_awready = ~st.aw_held & (st.wst == W_IDLE);
	assign s_axi_wready  = ~st.w_held & (st.wst == W_IDLE);
	assign s_axi_bvalid  = (st.wst == W_RESP);
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	assign range_code_a             = st.range_a;  // [R1]
	assign range_code_b             = st.range_b;  // [R2]
	// codes below 0x2000 are stored as written; the trim just degrades [R3]
	assign use_supply_reference     = st.ref_sel[analog_cfg_pkg::BIT_USE_SUPPLY];  // [R4]
	assign stamp_receiver_on        = st.stamp[analog_cfg_pkg::BIT_STAMP_ON];      // [R5]
	assign stamp_receiver_pecl_mode = st.stamp[analog_cfg_pkg::BIT_STAMP_PECL];    // [R6]
	assign lane_emphasis_level      = st.emphasis[2:0];                            // [R7]
	assign lane_emphasis_extra      = st.emphasis[analog_cfg_pkg::BIT_EMPH_EXTRA]; // [R8]
	assign calibration_run          = st.cal_ctrl[analog_cfg_pkg::BIT_CAL_ENABLE]; // [R15]

	// decoder sees only the calibrated copy of the mux byte
	input_route input_route_inst (
		.applied_sel   (st.applied_sel),
		.single_mode   (operating_mode_single),
		.chan_a_from_b (chan_a_from_b),
		.chan_b_from_a (chan_b_from_a),
		.sel_reserved  (sel_reserved)
	);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_range_a_reset: assert property (@(posedge aclk) !aresetn |=> range_code_a == 16'hA000) // [R1]
		else $error("range a not at reset value");
	a_range_b_reset: assert property (@(posedge aclk) !aresetn |=> range_code_b == 16'hA000) // [R2]
		else $error("range b not at reset value");
	a_mux_reset: assert property (@(posedge aclk) !aresetn |=> st.input_sel == 8'h01) // [R14]
		else $error("mux not at reset value");
	a_ref_reset_off: assert property (@(posedge aclk) !aresetn |=> !use_supply_reference && !stamp_receiver_on) // [R4]
		else $error("reference or receiver on after reset");
	a_mux_holds_nocal: assert property (@(posedge aclk) disable iff (!aresetn)
		!cal_rise |=> $stable(st.applied_sel)) // [R13]
		else $error("mux applied without calibration");
	a_mux_on_cal: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(calibration_run) |-> st.applied_sel == st.input_sel) // [R15]
		else $error("mux not applied at calibration");
	a_swap_dual: assert property (@(posedge aclk) disable iff (!aresetn)
		!operating_mode_single |-> chan_a_from_b == st.applied_sel[4] && chan_b_from_a == st.applied_sel[4]) // [R9]
		else $error("dual routing wrong");
	a_single_b: assert property (@(posedge aclk) disable iff (!aresetn)
		operating_mode_single && st.applied_sel[1:0] == 2'h2 |-> chan_a_from_b && !chan_b_from_a) // [R11]
		else $error("single input b routing wrong");
	a_write_stored: assert property (@(posedge aclk) disable iff (!aresetn)
		st.wst == W_IDLE && st.aw_held && st.w_held && widx == 8'h48 && st.wstrb[0]
		|=> lane_emphasis_level == $past(st.wdata[2:0]) && lane_emphasis_extra == $past(st.wdata[3])) // [R7]
		else $error("emphasis write lost");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // [R17]
		else $error("read not answered in one cycle");

	c_write_done: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	c_read_done: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_recal: cover property (@(posedge aclk) cal_rise && st.input_sel != st.applied_sel);

endmodule : analog_cfg_regs

// ==== verification/analog_cfg_regs_bench.sv ====
module analog_cfg_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------
	// bench signals
	// ---------------------------
	logic        aclk, aresetn;                       // clock and reset
	logic [9:0]  s_axi_awaddr, s_axi_araddr;          // bus addresses
	logic        s_axi_awvalid, s_axi_wvalid;         // write requests
	logic        s_axi_arvalid, s_axi_bready;         // read request, write answer ready
	logic        s_axi_rready;                        // read answer ready
	logic [31:0] s_axi_wdata;                         // write data
	logic [3:0]  s_axi_wstrb;                         // byte strobes
	logic        s_axi_awready, s_axi_wready;         // slave readies
	logic        s_axi_arready, s_axi_bvalid;         // slave readies and answers
	logic        s_axi_rvalid;                        // read answer valid
	logic [1:0]  s_axi_bresp, s_axi_rresp;            // response codes
	logic [31:0] s_axi_rdata;                         // read data
	logic        operating_mode_single;               // mode selector stand-in
	logic [15:0] range_code_a, range_code_b;          // full-scale trims
	logic        use_supply_reference;                // reference select
	logic        stamp_receiver_on;                   // receiver enable
	logic        stamp_receiver_pecl_mode;            // receiver signalling
	logic [2:0]  lane_emphasis_level;                 // emphasis level
	logic        lane_emphasis_extra;                 // emphasis boost
	logic        calibration_run;                     // calibration enable level
	logic        chan_a_from_b, chan_b_from_a;        // applied routing
	int          mismatches, n_tests;                 // report counters

	// ---------------------------
	// design and clock
	// ---------------------------
	analog_cfg_regs analog_cfg_regs_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.operating_mode_single, .range_code_a, .range_code_b, .use_supply_reference, .stamp_receiver_on,
		.stamp_receiver_pecl_mode, .lane_emphasis_level, .lane_emphasis_extra, .calibration_run,
		.chan_a_from_b, .chan_b_from_a
	);

	// 50 ns period
	always #25 aclk = ~aclk;

	// ---------------------------
	// shared tasks
	// ---------------------------
	// verdict and end of run, reached from the main sequence and from any stuck wait
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
			mismatches++;
		end
	endtask : check

	// readies are looked at on the falling edge, which is what the next rising edge samples
	task automatic axi_write(input logic [7:0] idx, input logic [31:0] data, output logic [1:0] resp);
		int   i;
		logic a, w, b;
		@(posedge aclk);
		s_axi_awaddr  <= {idx, 2'h0};
		s_axi_wdata   <= data;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(negedge aclk);
			if (!s_axi_awvalid && !s_axi_wvalid && !s_axi_bready)
				break;
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bready && s_axi_bvalid;
			if (b)
				resp = s_axi_bresp;
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (i == 40)
		begin
			mismatches++;
			stop_test();
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
		int   i;
		logic a, r;
		@(posedge aclk);
		s_axi_araddr  <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(negedge aclk);
			if (!s_axi_arvalid && !s_axi_rready)
				break;
			a = s_axi_arvalid && s_axi_arready;
			r = s_axi_rready && s_axi_rvalid;
			if (r)
			begin
				data = s_axi_rdata;
				resp = s_axi_rresp;
			end
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		if (i == 40)
		begin
			mismatches++;
			stop_test();
		end
	endtask : axi_read

	task automatic wr(input logic [7:0] idx, input logic [31:0] data);
		logic [1:0] r;
		axi_write(idx, data, r);
		check({30'h0, r}, {30'h0, analog_cfg_pkg::RESP_OKAY});
	endtask : wr

	task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(idx, d, r);
		check(d, exp);
		check({30'h0, r}, {30'h0, analog_cfg_pkg::RESP_OKAY});
	endtask : rd_check

	// expected {chan_a_from_b, chan_b_from_a} for a mode and an applied mux byte
	function automatic logic [1:0] route_exp(input logic single, input logic [7:0] sel);
		if (!single)
			return {2{sel[4]}};
		case (sel[1:0])
			analog_cfg_pkg::SEL_INPUT_A: return 2'h1;
			analog_cfg_pkg::SEL_INPUT_B: return 2'h2;
			default:                     return 2'h0;
		endcase
	endfunction : route_exp

	// ---------------------------
	// scenarios
	// ---------------------------
	task automatic scn_reset_values;
		rd_check(analog_cfg_pkg::IDX_RANGE_A, 32'h0000A000);
		rd_check(analog_cfg_pkg::IDX_RANGE_B, 32'h0000A000);
		rd_check(analog_cfg_pkg::IDX_REF_SEL, 32'h00000000);
		rd_check(analog_cfg_pkg::IDX_STAMP, 32'h00000000);
		rd_check(analog_cfg_pkg::IDX_EMPHASIS, 32'h00000000);
		rd_check(analog_cfg_pkg::IDX_INPUT_SEL, 32'h00000001);
		rd_check(analog_cfg_pkg::IDX_CAL_CTRL, 32'h00000001);
		check({range_code_a, range_code_b}, 32'hA000A000);
		check({25'h0, use_supply_reference, stamp_receiver_on, stamp_receiver_pecl_mode, lane_emphasis_level,
			lane_emphasis_extra}, 32'h00000000);
		check({29'h0, calibration_run, chan_a_from_b, chan_b_from_a}, 32'h00000004);
	endtask : scn_reset_values

	// two passes write two patterns to each of the five range, reference, timestamp and emphasis registers, reserved bits included; codes stay in the advised band
	task automatic scn_field_access;
		logic [7:0]  ix [5] = '{analog_cfg_pkg::IDX_RANGE_A, analog_cfg_pkg::IDX_RANGE_B,
			analog_cfg_pkg::IDX_REF_SEL, analog_cfg_pkg::IDX_STAMP, analog_cfg_pkg::IDX_EMPHASIS};
		logic [31:0] v [2][5] = '{'{32'h2000, 32'hFFFF, 32'hFF, 32'h02, 32'h0D},
			'{32'h5FFF, 32'h2001, 32'hFE, 32'hFD, 32'hF7}};
		for (int s = 0; s < 2; s++)
		begin
			for (int k = 0; k < 5; k++)
			begin
				wr(ix[k], v[s][k]);
				rd_check(ix[k], v[s][k]);
			end
			check({range_code_a, range_code_b}, {v[s][0][15:0], v[s][1][15:0]});
			check({31'h0, use_supply_reference}, {31'h0, v[s][2][0]});
			check({30'h0, stamp_receiver_pecl_mode, stamp_receiver_on}, {30'h0, v[s][3][1:0]});
			check({28'h0, lane_emphasis_extra, lane_emphasis_level}, {28'h0, v[s][4][3:0]});
		end
	endtask : scn_field_access

	// each mux byte must wait for the calibration 0 then 1 before routing moves
	task automatic scn_input_mux;
		logic [7:0] sel [9] = '{8'h02, 8'h03, 8'h00, 8'h12, 8'h01, 8'h10, 8'h02, 8'h11, 8'hE1};
		logic       mode [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		logic [7:0] prev = 8'h01;
		logic       cur = 1'b0;
		for (int k = 0; k < 9; k++)
		begin
			wr(analog_cfg_pkg::IDX_INPUT_SEL, {24'h0, sel[k]});
			rd_check(analog_cfg_pkg::IDX_INPUT_SEL, {24'h0, sel[k]});
			check({30'h0, chan_a_from_b, chan_b_from_a}, {30'h0, route_exp(cur, prev)});
			wr(analog_cfg_pkg::IDX_CAL_CTRL, 32'h0);
			check({29'h0, calibration_run, chan_a_from_b, chan_b_from_a}, {29'h0, 1'b0, route_exp(cur, prev)});
			wr(analog_cfg_pkg::IDX_CAL_CTRL, 32'h1);
			@(posedge aclk);
			operating_mode_single <= mode[k];
			@(negedge aclk);
			check({29'h0, calibration_run, chan_a_from_b, chan_b_from_a},
				{29'h0, 1'b1, route_exp(mode[k], sel[k])});
			rd_check(analog_cfg_pkg::IDX_STATUS,
				{23'h0, mode[k] && sel[k][1:0] == analog_cfg_pkg::SEL_RESERVED, sel[k]});
			prev = sel[k];
			cur = mode[k];
		end
	endtask : scn_input_mux

	// unmapped places and the read-only status refuse with an error and change nothing
	task automatic scn_bad_access;
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(8'h00, d, r);
		check(d, 32'h0);
		check({30'h0, r}, {30'h0, analog_cfg_pkg::RESP_SLVERR});
		axi_write(8'hFF, 32'hFFFFFFFF, r);
		check({30'h0, r}, {30'h0, analog_cfg_pkg::RESP_SLVERR});
		axi_write(analog_cfg_pkg::IDX_STATUS, 32'h0, r);
		check({30'h0, r}, {30'h0, analog_cfg_pkg::RESP_SLVERR});
		rd_check(analog_cfg_pkg::IDX_STATUS, 32'h000000E1);
	endtask : scn_bad_access

	// a second reset in mid-run brings every field back to its default
	task automatic scn_mid_reset;
		wr(analog_cfg_pkg::IDX_RANGE_A, 32'h3000);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		scn_reset_values();
	endtask : scn_mid_reset

	// ---------------------------
	// main sequence
	// ---------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
		operating_mode_single = 1'b0;
		mismatches = 0;
		n_tests = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		scn_reset_values();
		scn_field_access();
		scn_input_mux();
		scn_bad_access();
		scn_mid_reset();
		stop_test();
	end

endmodule : analog_cfg_regs_bench
